// [rtl/req_param_pkg.sv]
package req_param_pkg;
  // Command codes
  localparam logic [7:0] CMD_REQ = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h06;
  localparam logic [7:0] CMD_WRITE = 8'h08;
  // System code wildcards
  localparam logic [15:0] SC_ALL = 16'hFFFF;
  localparam logic [15:0] SC_CATEGORY = 16'hAAFF;
  localparam logic [7:0] SC_CAT_HI = 8'hAA;
  // Status pairs, first byte and second bytes
  localparam logic [7:0] ST1_ERR = 8'hFF;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST2_SVC_CNT = 8'hA1;
  localparam logic [7:0] ST2_BLK_CNT = 8'hA2;
  localparam logic [7:0] ST2_SVC_MIX = 8'hA3;
  localparam logic [7:0] ST2_BLK_SPEC = 8'hA5;
  // Descriptor fixed bytes
  localparam logic [7:0] RTD_ONES = 8'hFF;
  localparam logic [7:0] RTD_ZERO = 8'h00;
  // Security mode codes
  localparam logic [2:0] MODE_PLAIN = 3'h0;
  localparam logic [2:0] MODE_PRIV = 3'h2;
  localparam logic [2:0] MODE_FAM = 3'h3;
  // Limits
  localparam logic [7:0] MAX_SVC_READ = 8'h0F;
  localparam logic [7:0] MAX_SVC_WRITE = 8'h0B;
  localparam logic [7:0] WR_SVC_SPLIT = 8'h08;
  localparam logic [7:0] MAX_BLK_WR_LO = 8'h0C;
  localparam logic [7:0] MAX_BLK_WR_HI = 8'h0B;
  localparam logic [7:0] ENC_PARAM_BLKS = 8'h02;
  localparam logic [7:0] REQ_BODY_BYTES = 8'h04;
  localparam logic [7:0] IDM_BYTES = 8'h08;
  localparam int BLOCK_BYTES = 16;
  // Response wait unit, in carrier periods and in nanoseconds
  localparam int T_UNIT_CARRIER = 256 * 16;
  localparam int T_UNIT_NS = 302000;
  // Register byte offsets
  localparam logic [7:0] REG_SYSCODE = 8'h00;
  localparam logic [7:0] REG_ID_LO = 8'h04;
  localparam logic [7:0] REG_ID_HI = 8'h08;
  localparam logic [7:0] REG_TIMING = 8'h0C;
  localparam logic [7:0] REG_RD_LIMIT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  // Reset values
  localparam logic [15:0] RST_SYSCODE = 16'h0000;
  localparam logic [63:0] RST_ID = 64'h0000_0000_0000_0000;
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] RST_RD_LIMIT = 8'h0F;
  // Parser states, Gray along the listed order
  typedef enum logic [2:0] {
    ST_CODE = 3'b000,
    ST_REQ = 3'b001,
    ST_IDM = 3'b011,
    ST_SVN = 3'b010,
    ST_SVC = 3'b110,
    ST_BLN = 3'b111,
    ST_BLK = 3'b101,
    ST_SKIP = 3'b100
  } pstate_t;
endpackage

// [rtl/rfid_req_and_param_checker.sv]
// Operation
// - Wildcard system code always answers
// - Category wildcard needs upper stored byte AA
// - Otherwise answer only on exact match
// - Stored system code comes from configuration
// - Reply carries eight byte configured identifier
// - Descriptor bytes fixed except bytes five, six
// - Byte five READ timing, six WRITE
// - Wait is unit times blocks formula
// - Always answer in first time slot
// - Unequal service entries are rejected
// - Sixteen byte blocks, two/three byte elements
// - Nonzero access mode bits give error
// - Nonzero high third-byte bits give error
// - Mode code selects security, reserved errors
// - READ block limit configurable, confirm value
// - WRITE twelve blocks, eleven above eight services
// - Encrypted transfers spend two parameter blocks
// - Block spec errors report FF A5
// - Block count errors report FF A2
// - Service mix A3, service count A1
// - Only REQ, READ, WRITE are recognised
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module rfid_req_and_param_checker #(
  parameter int NUM_BLOCKS = 32
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic BYTE_VALID_I,
  input wire logic [7:0] BYTE_I,
  input wire logic FRAME_END_I,
  output logic DONE_O,
  output logic ANSWER_O,
  output logic [7:0] CMD_O,
  output logic [7:0] STATUS1_O,
  output logic [7:0] STATUS2_O,
  output logic [7:0] SLOT_O,
  output logic [63:0] ID_O,
  output logic [63:0] RTD_O,
  output logic [2:0] MODE_O,
  output logic [7:0] NBLK_O,
  output logic [17:0] WAIT_UNITS_O
);
  // Configuration held as loaded from non-volatile storage
  logic [15:0] stored_system_code_r;
  logic [63:0] card_identifier_field_r;
  logic [7:0] time_rd_r, time_wr_r;
  logic [7:0] rd_limit_r;
  // Bus handshake
  logic ack_r;
  logic req_act;
  // Parser state
  req_param_pkg::pstate_t st_r;
  logic [7:0] cmd_r, cnt_r, nsvc_r, nblk_r, idx_r, bno_r, bno_prev_r;
  logic [1:0] eb_r;
  logic len2_r;
  logic [15:0] sc_rx_r, svc0_r;
  logic [7:0] svc_hi_r;
  logic [2:0] mode0_r;
  logic [7:0] err_r;
  logic req_ok_r;
  // Element decode helpers
  logic el_last;
  logic [7:0] el_bno;
  logic [2:0] el_mode;
  logic el_enc;
  logic [7:0] wr_limit;
  logic sc_match;

  assign req_act = (AVS_READ_I | AVS_WRITE_I) & CE_I;
  // One wait cycle, then the answer edge
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;

  // Bus acknowledge and read data
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ack_r <= 1'b0;
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (CE_I) begin
      ack_r <= req_act & ~ack_r;
      if (AVS_READ_I & ~ack_r) begin
        case (AVS_ADDRESS_I)
          req_param_pkg::REG_SYSCODE:
            AVS_READDATA_O <= {16'h0000, stored_system_code_r};
          req_param_pkg::REG_ID_LO:
            AVS_READDATA_O <= card_identifier_field_r[31:0];
          req_param_pkg::REG_ID_HI:
            AVS_READDATA_O <= card_identifier_field_r[63:32];
          req_param_pkg::REG_TIMING:
            AVS_READDATA_O <= {16'h0000, time_wr_r, time_rd_r};
          req_param_pkg::REG_RD_LIMIT:
            AVS_READDATA_O <= {24'h00_0000, rd_limit_r};
          req_param_pkg::REG_STATUS:
            AVS_READDATA_O <= {cmd_r, STATUS2_O, 5'h00, st_r,
                               7'h00, ANSWER_O};
          // Unmapped offsets read zero
          default: AVS_READDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration writes land on the answer edge
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      stored_system_code_r <= req_param_pkg::RST_SYSCODE;
      card_identifier_field_r <= req_param_pkg::RST_ID;
      time_rd_r <= req_param_pkg::RST_TIMING;
      time_wr_r <= req_param_pkg::RST_TIMING;
      rd_limit_r <= req_param_pkg::RST_RD_LIMIT;
    end else if (CE_I && AVS_WRITE_I && ack_r) begin
      case (AVS_ADDRESS_I)
        req_param_pkg::REG_SYSCODE:
          stored_system_code_r <= AVS_WRITEDATA_I[15:0];
        req_param_pkg::REG_ID_LO:
          card_identifier_field_r[31:0] <= AVS_WRITEDATA_I;
        req_param_pkg::REG_ID_HI:
          card_identifier_field_r[63:32] <= AVS_WRITEDATA_I;
        req_param_pkg::REG_TIMING: begin
          time_rd_r <= AVS_WRITEDATA_I[7:0];
          time_wr_r <= AVS_WRITEDATA_I[15:8];
        end
        // Limit left to software until the true figure is settled
        req_param_pkg::REG_RD_LIMIT:
          rd_limit_r <= AVS_WRITEDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // Element field decode for the current byte
  always_comb begin
    el_last = (eb_r == 2'd1 && len2_r) || eb_r == 2'd2;
    el_bno = (eb_r == 2'd1) ? BYTE_I : bno_r;
    el_mode = (eb_r == 2'd2) ? BYTE_I[2:0]
                             : req_param_pkg::MODE_PLAIN;
    el_enc = el_mode != req_param_pkg::MODE_PLAIN;
    wr_limit = (nsvc_r <= req_param_pkg::WR_SVC_SPLIT)
               ? req_param_pkg::MAX_BLK_WR_LO
               : req_param_pkg::MAX_BLK_WR_HI;
  end

  // REQ system code selection
  always_comb begin
    if (sc_rx_r == req_param_pkg::SC_ALL) begin
      sc_match = 1'b1;
    end else if (sc_rx_r == req_param_pkg::SC_CATEGORY) begin
      sc_match = stored_system_code_r[15:8] ==
                 req_param_pkg::SC_CAT_HI;
    end else begin
      sc_match = sc_rx_r == stored_system_code_r;
    end
  end

  // Byte parser; the first error found is kept
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_r <= req_param_pkg::ST_CODE;
      cmd_r <= 8'h00;
      cnt_r <= 8'h00;
      nsvc_r <= 8'h00;
      nblk_r <= 8'h00;
      idx_r <= 8'h00;
      bno_r <= 8'h00;
      bno_prev_r <= 8'h00;
      eb_r <= 2'd0;
      len2_r <= 1'b0;
      sc_rx_r <= 16'h0000;
      svc0_r <= 16'h0000;
      svc_hi_r <= 8'h00;
      mode0_r <= 3'h0;
      err_r <= 8'h00;
      req_ok_r <= 1'b0;
    end else if (CE_I) begin
      if (FRAME_END_I) begin
        // Frame over, next byte is a command code
        st_r <= req_param_pkg::ST_CODE;
      end else if (BYTE_VALID_I) begin
        case (st_r)
          req_param_pkg::ST_CODE: begin
            cmd_r <= BYTE_I;
            cnt_r <= 8'h00;
            err_r <= 8'h00;
            req_ok_r <= 1'b0;
            idx_r <= 8'h00;
            eb_r <= 2'd0;
            // Unknown codes are skipped silently
            if (BYTE_I == req_param_pkg::CMD_REQ) begin
              st_r <= req_param_pkg::ST_REQ;
            end else if (BYTE_I == req_param_pkg::CMD_READ ||
                         BYTE_I == req_param_pkg::CMD_WRITE) begin
              st_r <= req_param_pkg::ST_IDM;
            end else begin
              st_r <= req_param_pkg::ST_SKIP;
            end
          end
          req_param_pkg::ST_REQ: begin
            // System code MSB first, then request code and slots
            if (cnt_r == 8'd0) sc_rx_r[15:8] <= BYTE_I;
            if (cnt_r == 8'd1) sc_rx_r[7:0] <= BYTE_I;
            cnt_r <= cnt_r + 8'd1;
            if (cnt_r == req_param_pkg::REQ_BODY_BYTES - 8'd1) begin
              req_ok_r <= 1'b1;
              st_r <= req_param_pkg::ST_SKIP;
            end
          end
          req_param_pkg::ST_IDM: begin
            cnt_r <= cnt_r + 8'd1;
            if (cnt_r == req_param_pkg::IDM_BYTES - 8'd1) begin
              st_r <= req_param_pkg::ST_SVN;
            end
          end
          req_param_pkg::ST_SVN: begin
            nsvc_r <= BYTE_I;
            cnt_r <= 8'h00;
            if (BYTE_I == 8'h00 ||
                (cmd_r == req_param_pkg::CMD_READ &&
                 BYTE_I > req_param_pkg::MAX_SVC_READ) ||
                (cmd_r == req_param_pkg::CMD_WRITE &&
                 BYTE_I > req_param_pkg::MAX_SVC_WRITE)) begin
              err_r <= req_param_pkg::ST2_SVC_CNT;
              st_r <= req_param_pkg::ST_SKIP;
            end else begin
              st_r <= req_param_pkg::ST_SVC;
            end
          end
          req_param_pkg::ST_SVC: begin
            cnt_r <= cnt_r + 8'd1;
            if (!cnt_r[0]) begin
              svc_hi_r <= BYTE_I;
            end else if (cnt_r == 8'd1) begin
              svc0_r <= {svc_hi_r, BYTE_I};
            end else if ({svc_hi_r, BYTE_I} != svc0_r &&
                         err_r == 8'h00) begin
              err_r <= req_param_pkg::ST2_SVC_MIX;
            end
            if (cnt_r == {nsvc_r[6:0], 1'b0} - 8'd1) begin
              st_r <= req_param_pkg::ST_BLN;
            end
          end
          req_param_pkg::ST_BLN: begin
            nblk_r <= BYTE_I;
            if (BYTE_I == 8'h00 ||
                (cmd_r == req_param_pkg::CMD_READ &&
                 BYTE_I > rd_limit_r) ||
                (cmd_r == req_param_pkg::CMD_WRITE &&
                 BYTE_I > wr_limit)) begin
              if (err_r == 8'h00) begin
                err_r <= req_param_pkg::ST2_BLK_CNT;
              end
              st_r <= req_param_pkg::ST_SKIP;
            end else begin
              st_r <= req_param_pkg::ST_BLK;
            end
          end
          req_param_pkg::ST_BLK: begin
            eb_r <= el_last ? 2'd0 : eb_r + 2'd1;
            if (eb_r == 2'd0) begin
              len2_r <= BYTE_I[7];
              if (BYTE_I[6:4] != 3'h0 && err_r == 8'h00) begin
                err_r <= req_param_pkg::ST2_BLK_SPEC;
              end
            end
            if (eb_r == 2'd1) begin
              bno_r <= BYTE_I;
              if (BYTE_I >= 8'(NUM_BLOCKS) && err_r == 8'h00) begin
                err_r <= req_param_pkg::ST2_BLK_SPEC;
              end
            end
            if (eb_r == 2'd2 && err_r == 8'h00 &&
                (BYTE_I[7:3] != 5'h00 ||
                 (BYTE_I[2:0] != req_param_pkg::MODE_PLAIN &&
                  BYTE_I[2:0] != req_param_pkg::MODE_PRIV &&
                  BYTE_I[2:0] != req_param_pkg::MODE_FAM))) begin
              err_r <= req_param_pkg::ST2_BLK_SPEC;
            end
            if (el_last) begin
              idx_r <= idx_r + 8'd1;
              bno_prev_r <= el_bno;
              if (idx_r == 8'h00) mode0_r <= el_mode;
              if (err_r == 8'h00 && idx_r != 8'h00 &&
                  (el_mode != mode0_r ||
                   (el_enc && idx_r + req_param_pkg::ENC_PARAM_BLKS
                    < nblk_r && el_bno <= bno_prev_r))) begin
                err_r <= req_param_pkg::ST2_BLK_SPEC;
              end
              if (idx_r == nblk_r - 8'd1) begin
                // Encrypted needs room for IV and MAC plus data
                if (err_r == 8'h00 && el_enc &&
                    nblk_r <= req_param_pkg::ENC_PARAM_BLKS) begin
                  err_r <= req_param_pkg::ST2_BLK_CNT;
                end
                req_ok_r <= 1'b1;
                st_r <= req_param_pkg::ST_SKIP;
              end
            end
          end
          req_param_pkg::ST_SKIP: ;
          default: st_r <= req_param_pkg::ST_CODE;
        endcase
      end
    end
  end

  // Verdict at end of frame
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      DONE_O <= 1'b0;
      ANSWER_O <= 1'b0;
      CMD_O <= 8'h00;
      STATUS1_O <= req_param_pkg::ST_OK;
      STATUS2_O <= req_param_pkg::ST_OK;
      SLOT_O <= 8'h00;
      ID_O <= req_param_pkg::RST_ID;
      RTD_O <= 64'h0000_0000_0000_0000;
      MODE_O <= 3'h0;
      NBLK_O <= 8'h00;
      WAIT_UNITS_O <= 18'h0_0000;
    end else if (CE_I) begin
      DONE_O <= FRAME_END_I;
      if (FRAME_END_I) begin
        CMD_O <= cmd_r;
        SLOT_O <= 8'h00;
        MODE_O <= mode0_r;
        NBLK_O <= nblk_r;
        STATUS1_O <= (err_r != 8'h00) ? req_param_pkg::ST1_ERR
                                      : req_param_pkg::ST_OK;
        STATUS2_O <= err_r;
        if (cmd_r == req_param_pkg::CMD_REQ) begin
          // Silent unless the body was whole and the code matched
          ANSWER_O <= req_ok_r && sc_match;
          ID_O <= card_identifier_field_r;
          RTD_O <= {req_param_pkg::RTD_ONES, req_param_pkg::RTD_ONES,
                    req_param_pkg::RTD_ZERO, req_param_pkg::RTD_ZERO,
                    req_param_pkg::RTD_ZERO, time_rd_r, time_wr_r,
                    req_param_pkg::RTD_ONES};
        end else begin
          // Short frames stay silent; errors still answer
          ANSWER_O <= (cmd_r == req_param_pkg::CMD_READ ||
                       cmd_r == req_param_pkg::CMD_WRITE) &&
                      (req_ok_r || err_r != 8'h00);
        end
        // Units of T: ((B+1)n+(A+1)) times four to the E
        if (cmd_r == req_param_pkg::CMD_READ) begin
          WAIT_UNITS_O <= 18'((({15'h0, time_rd_r[5:3]} + 18'd1) *
                          {10'h0, nblk_r} + {15'h0, time_rd_r[2:0]}
                          + 18'd1) << {time_rd_r[7:6], 1'b0});
        end else begin
          WAIT_UNITS_O <= 18'((({15'h0, time_wr_r[5:3]} + 18'd1) *
                          {10'h0, nblk_r} + {15'h0, time_wr_r[2:0]}
                          + 18'd1) << {time_wr_r[7:6], 1'b0});
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verif/rfid_req_and_param_checker_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
// Judges results against frame bytes and bus-written config
module rfid_req_and_param_checker_asserts (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic BYTE_VALID_I,
  input wire logic [7:0] BYTE_I,
  input wire logic FRAME_END_I,
  input wire logic DONE_O,
  input wire logic ANSWER_O,
  input wire logic [7:0] CMD_O,
  input wire logic [7:0] STATUS1_O,
  input wire logic [7:0] STATUS2_O,
  input wire logic [7:0] SLOT_O,
  input wire logic [63:0] RTD_O,
  input wire logic [7:0] NBLK_O,
  input wire logic [17:0] WAIT_UNITS_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  logic [7:0] cnt_r; // Bytes seen in this frame
  logic [15:0] sc_r; // Requested system code
  logic [15:0] st_r; // Copy of stored system code
  logic [15:0] tm_r; // Copy of timing pair
  logic wr_ok; // Write lands this edge
  logic req_done; // Full REQ just finished
  logic [17:0] wexp; // Expected READ wait
  assign wr_ok = CE_I && AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign req_done = DONE_O && CMD_O == 8'h00 && cnt_r >= 8'h05;
  // Shift by twice E is the power of four
  assign wexp = ((18'(tm_r[5:3]) + 18'h1) * 18'(NBLK_O)
    + 18'(tm_r[2:0]) + 18'h1) << {tm_r[7:6], 1'b0};
  // Frame byte count, cleared once the result is out
  always_ff @(posedge CLK_I) begin
    if (SRST_I || DONE_O) begin
      cnt_r <= 8'h00;
    end else if (BYTE_VALID_I && CE_I) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // System code bytes follow the command code
  always_ff @(posedge CLK_I) begin
    if (BYTE_VALID_I && CE_I && cnt_r == 8'h01) begin
      sc_r[15:8] <= BYTE_I;
    end
    if (BYTE_VALID_I && CE_I && cnt_r == 8'h02) begin
      sc_r[7:0] <= BYTE_I;
    end
  end
  // Config mirror; unmapped writes never reach it
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_r <= 16'h0000;
      tm_r <= 16'h0000;
    end else if (wr_ok && AVS_ADDRESS_I == 8'h00) begin
      st_r <= AVS_WRITEDATA_I[15:0];
    end else if (wr_ok && AVS_ADDRESS_I == 8'h0C) begin
      tm_r <= AVS_WRITEDATA_I[15:0];
    end
  end
  property p_wild;
    req_done && sc_r == 16'hFFFF |-> ANSWER_O;
  endproperty
  a_wild: assert property (p_wild)
    else $error("wildcard request not answered");
  property p_cat;
    req_done && sc_r == 16'hAAFF |-> ANSWER_O == (st_r[15:8] == 8'hAA);
  endproperty
  a_cat: assert property (p_cat)
    else $error("category request answered wrongly");
  property p_exact;
    req_done && sc_r != 16'hFFFF && sc_r != 16'hAAFF
      |-> ANSWER_O == (sc_r == st_r);
  endproperty
  a_exact: assert property (p_exact)
    else $error("exact match answer wrong");
  property p_done;
    FRAME_END_I && CE_I |=> DONE_O && SLOT_O == 8'h00 ##1 !DONE_O;
  endproperty
  a_done: assert property (p_done)
    else $error("done pulse or slot wrong");
  property p_rtd;
    req_done && ANSWER_O |-> RTD_O == {16'hFFFF, 24'h00_0000, tm_r[7:0],
      tm_r[15:8], 8'hFF};
  endproperty
  a_rtd: assert property (p_rtd)
    else $error("descriptor bytes wrong");
  property p_unknown;
    DONE_O && !(CMD_O inside {8'h00, 8'h06, 8'h08}) |-> !ANSWER_O;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown command answered");
  property p_wait;
    DONE_O && CMD_O == 8'h06 && STATUS1_O == 8'h00 |-> WAIT_UNITS_O == wexp;
  endproperty
  a_wait: assert property (p_wait)
    else $error("read wait units wrong");
  property p_status;
    DONE_O |-> STATUS1_O == 8'h00 && STATUS2_O == 8'h00 || STATUS1_O ==
      8'hFF && STATUS2_O inside {8'hA1, 8'hA2, 8'hA3, 8'hA5};
  endproperty
  a_status: assert property (p_status)
    else $error("status pair not a legal code");
  property p_bus;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && CE_I
      |=> !AVS_WAITREQUEST_O;
  endproperty
  a_bus: assert property (p_bus)
    else $error("config access not acknowledged");
endmodule
bind rfid_req_and_param_checker rfid_req_and_param_checker_asserts chk (
  .CLK_I, .SRST_I, .CE_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_WRITEDATA_I, .AVS_WAITREQUEST_O, .BYTE_VALID_I, .BYTE_I,
  .FRAME_END_I, .DONE_O, .ANSWER_O, .CMD_O, .STATUS1_O, .STATUS2_O,
  .SLOT_O, .RTD_O, .NBLK_O, .WAIT_UNITS_O
);
`default_nettype wire

// [verif/cmd_reader_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Reader side of the link: sends whole command frames
module cmd_reader_model (
  input wire logic clk_i,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic frame_end_o
);
  // Lines idle from time zero
  initial begin
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
    frame_end_o = 1'b0;
  end
  // Gap cycles between bytes model a slow reader
  task automatic send(input logic [7:0] b[$], input int gap);
    foreach (b[i]) begin
      @(posedge clk_i);
      byte_valid_o <= 1'b1;
      byte_o <= b[i];
      repeat (gap) begin
        @(posedge clk_i);
        byte_valid_o <= 1'b0;
        byte_o <= ~b[i]; // Stale data never left standing
      end
    end
    @(posedge clk_i);
    byte_valid_o <= 1'b0;
    byte_o <= ~b[b.size()-1];
    frame_end_o <= 1'b1; // End mark after last byte, never with it
    @(posedge clk_i);
    frame_end_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/rfid_req_and_param_checker_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module rfid_req_and_param_checker_bench;
  logic clk = 1'b0; // 100 MHz
  logic srst = 1'b1; // Held for five cycles
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wreq, bv, fe, done, ans;
  logic [7:0] bt, cmd, s1, s2, slot, nblk;
  logic [63:0] id, rtd;
  logic [2:0] mode;
  logic [17:0] wu;
  logic [7:0] q[$]; // Frame being built
  int fails = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  rfid_req_and_param_checker uut (.CLK_I(clk), .SRST_I(srst), .CE_I(1'b1),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .BYTE_VALID_I(bv), .BYTE_I(bt),
    .FRAME_END_I(fe), .DONE_O(done), .ANSWER_O(ans), .CMD_O(cmd),
    .STATUS1_O(s1), .STATUS2_O(s2), .SLOT_O(slot), .ID_O(id), .RTD_O(rtd),
    .MODE_O(mode), .NBLK_O(nblk), .WAIT_UNITS_O(wu));
  cmd_reader_model rdr (.clk_i(clk), .byte_valid_o(bv), .byte_o(bt),
    .frame_end_o(fe));
  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] v);
    int i;
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 8) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
      input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    chk(n, e, v);
  endtask
  // Send the built frame, then wait a bounded time for the result
  task automatic go(input int gap);
    int i;
    rdr.send(q, gap);
    #1;
    for (i = 0; i < 30 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask
  // READ or WRITE frame; block numbers ascend from the element's base
  task automatic rw(input logic [7:0] c, ns, input logic mix,
      input logic [7:0] nb, input logic [23:0] el, input logic [7:0] e2);
    q = {c};
    repeat (8) q.push_back(8'h11);
    q.push_back(ns);
    for (int i = 0; i < ns; i++) begin
      q.push_back((mix && i == 1) ? 8'h0A : 8'h09);
      q.push_back(8'h00);
    end
    q.push_back(nb);
    for (int i = 0; i < nb; i++) begin
      q.push_back(el[23:16]);
      q.push_back(el[15:8] + 8'(i));
      if (!el[23]) q.push_back(el[7:0]);
    end
    go(0);
    chk("cmd", c, cmd);
    chk("answer", 1'b1, ans);
    chk("status1", (e2 != 8'h00) ? 8'hFF : 8'h00, s1);
    chk("status2", e2, s2);
  endtask
  task automatic s_regs();
    rchk("syscode", 8'h00, 32'h0000_0000);
    rchk("read limit", 8'h10, 32'h0000_000F);
    wreg(8'h04, 32'h89AB_CDEF);
    wreg(8'h08, 32'h0123_4567);
    wreg(8'h0C, 32'h0000_814A);
    wreg(8'h40, 32'h5555_5555);
    rchk("id hi", 8'h08, 32'h0123_4567);
    rchk("timing", 8'h0C, 32'h0000_814A);
    rchk("unmapped", 8'h40, 32'h0000_0000);
  endtask
  // Stored code, requested code, expected answer
  task automatic s_req();
    logic [47:0] t [5] = '{48'h1234_FFFF_0001, 48'hAA55_AAFF_0001,
      48'h1234_AAFF_0000, 48'h1234_1234_0001, 48'h1234_1235_0000};
    foreach (t[k]) begin
      wreg(8'h00, {16'h0000, t[k][47:32]});
      q = {8'h00, t[k][31:24], t[k][23:16], 8'h00, 8'h0F};
      go(1);
      chk("answer", t[k][0], ans);
      chk("slot", 8'h00, slot);
      if (t[k][0]) begin
        chk("id", 64'h0123_4567_89AB_CDEF, id);
        chk("rtd", 64'hFFFF_0000_004A_81FF, rtd);
      end
    end
    rchk("syscode back", 8'h00, 32'h0000_1234);
  endtask
  task automatic s_cmd();
    q = {8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
    go(0);
    chk("answer", 1'b1, ans);
    q = {8'h07, 8'hFF, 8'hFF, 8'h00, 8'h00};
    go(0);
    chk("answer", 1'b0, ans);
    // Status view: last code 07, no error, parser idle, silent
    rchk("status reg", 8'h14, 32'h0700_0000);
  endtask
  task automatic s_svc();
    rw(8'h06, 8'h0F, 1'b0, 8'h01, 24'h80_0000, 8'h00);
    rw(8'h06, 8'h10, 1'b0, 8'h01, 24'h80_0000, 8'hA1);
    rw(8'h08, 8'h0B, 1'b0, 8'h01, 24'h80_0000, 8'h00);
    rw(8'h08, 8'h0C, 1'b0, 8'h01, 24'h80_0000, 8'hA1);
    rw(8'h06, 8'h03, 1'b1, 8'h01, 24'h80_0000, 8'hA3);
  endtask
  task automatic s_blk();
    rw(8'h06, 8'h01, 1'b0, 8'h0F, 24'h80_0000, 8'h00);
    rw(8'h06, 8'h01, 1'b0, 8'h10, 24'h80_0000, 8'hA2);
    wreg(8'h10, 32'h0000_000D);
    rchk("read limit back", 8'h10, 32'h0000_000D);
    rw(8'h06, 8'h01, 1'b0, 8'h0E, 24'h80_0000, 8'hA2);
    rw(8'h06, 8'h01, 1'b0, 8'h0D, 24'h80_0000, 8'h00);
    rw(8'h08, 8'h08, 1'b0, 8'h0C, 24'h80_0000, 8'h00);
    rw(8'h08, 8'h08, 1'b0, 8'h0D, 24'h80_0000, 8'hA2);
    rw(8'h08, 8'h09, 1'b0, 8'h0C, 24'h80_0000, 8'hA2);
    rw(8'h08, 8'h09, 1'b0, 8'h0B, 24'h80_0000, 8'h00);
    rw(8'h06, 8'h01, 1'b0, 8'h02, 24'h00_0002, 8'hA2);
    rw(8'h06, 8'h01, 1'b0, 8'h03, 24'h00_0002, 8'h00);
  endtask
  task automatic s_elem();
    rw(8'h06, 8'h01, 1'b0, 8'h01, 24'h90_0000, 8'hA5);
    rw(8'h06, 8'h01, 1'b0, 8'h01, 24'h00_0008, 8'hA5);
    rw(8'h06, 8'h01, 1'b0, 8'h02, 24'h80_1F00, 8'hA5);
    for (int m = 0; m < 8; m++) begin
      rw(8'h06, 8'h01, 1'b0, 8'h03, {21'h0, 3'(m)},
        (m == 0 || m == 2 || m == 3) ? 8'h00 : 8'hA5);
      if (m == 0 || m == 2 || m == 3) chk("mode", 3'(m), mode);
    end
  endtask
  task automatic s_wait();
    wreg(8'h0C, 32'h0000_4153);
    rw(8'h06, 8'h01, 1'b0, 8'h04, 24'h80_0000, 8'h00);
    chk("wait read", 18'h40, wu);
    rw(8'h08, 8'h01, 1'b0, 8'h02, 24'h80_0000, 8'h00);
    chk("nblk", 8'h02, nblk);
    chk("wait write", 18'h10, wu);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    s_regs();
    s_req();
    s_cmd();
    s_svc();
    s_blk();
    s_elem();
    s_wait();
    tally_and_finish();
  end
endmodule
`default_nettype wire
